// ===== pkg/sswe_clk_if.sv
// Purpose: quarter-phase and standby signals between core and phase maker
// Assumes: both ends run on the same oscillator clock
// Notes:   halt_req is sampled only in the last quarter
`timescale 1ns/1ps
interface sswe_clk_if;
	logic [1:0] q;
	logic       running;
	logic       standby;
	logic       ost_busy;
	logic       halt_req;
	logic       wake_req;

	modport gen  (output q, running, standby, ost_busy,
	              input  halt_req, wake_req);
	modport core (input  q, running, standby, ost_busy,
	              output halt_req, wake_req);
endinterface

// ===== pkg/sswe_pkg.sv
// Purpose: shared constants and types of the standby/subtract execute block
// Assumes: clk_i is the oscillator input, one clock per oscillator period
// Notes:   register offsets are byte addresses on a 32-bit wishbone bus
package sswe_pkg;

	// register byte offsets
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_FETCH  = 8'h04;
	localparam logic [7:0] ADR_W      = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0c;
	localparam logic [7:0] ADR_WDT    = 8'h10;
	localparam logic [7:0] ADR_TMR    = 8'h14;
	localparam logic [7:0] ADR_PORT   = 8'h18;
	localparam logic [7:0] ADR_PC     = 8'h1c;

	// control fields
	localparam int         CTRL_WAKE_BIT = 0;
	localparam int         CTRL_PSA_BIT  = 1;
	localparam logic       CTRL_PSA_RST  = 1'b1;

	// fetch register fields
	localparam int         FETCH_VALID_BIT = 16;
	localparam int         IW              = 14;

	// status fields
	localparam int         ST_C    = 0;
	localparam int         ST_DC   = 1;
	localparam int         ST_Z    = 2;
	localparam int         ST_PD   = 3;
	localparam int         ST_TO   = 4;
	localparam int         ST_STBY = 5;
	localparam int         ST_OST  = 6;
	localparam int         PORT_PIN_LSB = 8;

	// instruction encodings
	localparam logic [13:0] OP_NOP    = 14'h0000;
	localparam logic [13:0] OP_SLEEP  = 14'h0063;
	localparam logic [13:0] OP_WATCHDOG_CLEAR_INSTR = 14'h0064;
	localparam logic [4:0]  SUBTRACT_W_FROM_LITERAL_HI  = 5'h1e;
	localparam logic [2:0]  GOTO_HI   = 3'h5;
	localparam logic [1:0]  BYTE_HI   = 2'h0;
	localparam logic [3:0]  BOP_MOVWF  = 4'h0;
	localparam logic [3:0]  BOP_MOVF   = 4'h8;
	localparam logic [3:0]  BOP_COMF   = 4'h9;
	localparam logic [3:0]  BOP_INCF   = 4'ha;
	localparam logic [3:0]  BOP_DECFSZ = 4'hb;
	localparam int          D_BIT      = 7;
	localparam logic [6:0]  F_TIMER_ZERO_COUNT     = 7'h01;
	localparam logic [6:0]  F_PORT     = 7'h05;
	localparam int          PC_W       = 11;

	// quarter phases of one instruction cycle
	localparam logic [1:0]  Q1 = 2'h0;
	localparam logic [1:0]  Q2 = 2'h1;
	localparam logic [1:0]  Q3 = 2'h2;
	localparam logic [1:0]  Q4 = 2'h3;

	// timing
	localparam int          OST_TOSC     = 1024;
	localparam int          CLK_PER_TOSC = 1;
	localparam int          OST_CYC      = OST_TOSC * CLK_PER_TOSC;
	localparam int          OST_CNT_W    = 11;
	localparam logic [7:0]  CNT_MAX      = 8'hff;
	localparam logic [7:0]  RESET_VAL_8  = 8'h00;

	typedef enum logic [1:0] {
		SSWE_OST,
		SSWE_RUN,
		SSWE_HALT
	} sswe_clk_state_t;

endpackage

// ===== rtl/sswe_core.sv
// Purpose: executes standby, watchdog clear, subtract from literal and
//          a small set of byte, jump and skip instructions
// Assumes: software feeds instruction words over wishbone
// Notes:   wishbone ack comes one cycle after the request
//
// How it works
// RULE_01 - read-modify-write of the port takes the synchronised pin levels
// RULE_02 - writing timer zero clears the prescaler when timer owns it
// RULE_03 - jumps and taken skips run a second cycle as a no-operation
// RULE_04 - standby instruction zeroes watchdog counter and its prescaler
// RULE_05 - standby clears powerdown flag and sets timeout flag only
// RULE_06 - standby decodes, idles two quarters, enters standby in last
// RULE_07 - subtract: literal minus working register, result into W
// RULE_08 - subtract updates carry, digit carry and zero; carry means no borrow
// RULE_09 - subtract reads literal Q2, computes Q3, writes W in Q4
// RULE_10 - an instruction cycle is four oscillator clocks
// RULE_11 - start-up timer waits 1024 oscillator clocks before running
// RULE_12 - watchdog clear touches only the timeout and powerdown flags
// RULE_13 - PC increments in Q1 while the next word is prefetched
`timescale 1ns/1ps
module sswe_core (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  port_pins_i,
	output logic      [7:0]  port_latch_o,
	output logic             standby_o,
	output logic      [1:0]  q_phase_o
);
	sswe_clk_if cif ();

	sswe_qgen u_qgen (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.cif       (cif.gen)
	);

	// byte-lane merge of a bus write into an old value
	function automatic logic [31:0] sswe_merge(input logic [31:0] old,
	                                           input logic [31:0] dat,
	                                           input logic [3:0]  sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (dat & m);
	endfunction

	// literal minus w as {dc, c, result}, carry set means no borrow
	function automatic logic [9:0] sswe_sub(input logic [7:0] k,
	                                        input logic [7:0] w);
		logic [8:0] full;
		logic [4:0] low;
		full = {1'b0, k} + {1'b0, ~w} + 9'h001;
		low  = {1'b0, k[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
		return {low[4], full[8], full[7:0]};
	endfunction

	localparam int IW_W = sswe_pkg::IW;

	logic             ack_r;
	logic [31:0]      rdat_r;
	logic             psa_r;
	logic             wake_r;
	logic [IW_W-1:0]  fetch_r;
	logic             fetch_vld_r;
	logic [IW_W-1:0]  ir_r;
	logic [sswe_pkg::PC_W-1:0] pc_r;
	logic [7:0]       w_r;
	logic             c_r;
	logic             dc_r;
	logic             z_r;
	logic             pd_r;
	logic             to_r;
	logic [7:0]       opnd_r;
	logic [9:0]       alu_r;
	logic             skip_r;
	logic [7:0]       wdt_r;
	logic [7:0]       presc_r;
	logic [7:0]       tmr_r;
	logic [7:0]       latch_r;
	logic [7:0]       pins_m_r;
	logic [7:0]       pins_s_r;

	// bus strobes
	logic bus_req;
	logic bus_wr;
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
	assign bus_wr  = bus_req && wb_we_i;

	// instruction decode
	logic [6:0] f_adr;
	logic       d_file;
	logic [3:0] bop;
	logic       is_byte;
	logic       is_subtract_w_from_literal;
	logic       is_sleep;
	logic       is_watchdog_clear_instr;
	logic       is_goto;
	logic       is_wrf;
	logic       at_q4;
	assign f_adr     = ir_r[6:0];
	assign d_file    = ir_r[sswe_pkg::D_BIT];
	assign bop       = ir_r[11:8];
	assign is_byte   = ir_r[13:12] == sswe_pkg::BYTE_HI &&
	                   (bop != sswe_pkg::BOP_MOVWF || d_file);
	assign is_subtract_w_from_literal  = ir_r[13:9] == sswe_pkg::SUBTRACT_W_FROM_LITERAL_HI;
	assign is_sleep  = ir_r == sswe_pkg::OP_SLEEP;
	assign is_watchdog_clear_instr = ir_r == sswe_pkg::OP_WATCHDOG_CLEAR_INSTR;
	assign is_goto   = ir_r[13:11] == sswe_pkg::GOTO_HI;
	assign is_wrf    = is_byte && d_file;
	assign at_q4     = cif.running && cif.q == sswe_pkg::Q4;

	// standby request sampled by the phase maker in Q4
	assign cif.halt_req = is_sleep; // see RULE_06
	assign cif.wake_req = wake_r;

	assign wb_ack_o     = ack_r;
	assign wb_dat_o     = rdat_r;
	assign port_latch_o = latch_r;
	assign standby_o    = cif.standby;
	assign q_phase_o    = cif.q;

	// two-stage synchroniser on the port pins
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pins_m_r <= sswe_pkg::RESET_VAL_8;
			pins_s_r <= sswe_pkg::RESET_VAL_8;
		end else begin
			pins_m_r <= port_pins_i;
			pins_s_r <= pins_m_r;
		end
	end

	// wishbone ack, one cycle per request
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req;
		end
	end

	// read data, unmapped reads answer zero
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdat_r <= '0;
		end else if (bus_req) begin
			case (wb_adr_i)
				sswe_pkg::ADR_CTRL:   rdat_r <= 32'(psa_r) <<
				                          sswe_pkg::CTRL_PSA_BIT;
				sswe_pkg::ADR_FETCH:  rdat_r <= 32'(fetch_r) |
				                          (32'(fetch_vld_r) <<
				                           sswe_pkg::FETCH_VALID_BIT);
				sswe_pkg::ADR_W:      rdat_r <= 32'(w_r);
				sswe_pkg::ADR_STATUS: rdat_r <=
				    (32'(c_r)          << sswe_pkg::ST_C)  |
				    (32'(dc_r)         << sswe_pkg::ST_DC) |
				    (32'(z_r)          << sswe_pkg::ST_Z)  |
				    (32'(pd_r)         << sswe_pkg::ST_PD) |
				    (32'(to_r)         << sswe_pkg::ST_TO) |
				    (32'(cif.standby)  << sswe_pkg::ST_STBY) |
				    (32'(cif.ost_busy) << sswe_pkg::ST_OST);
				sswe_pkg::ADR_WDT:    rdat_r <= 32'(wdt_r);
				sswe_pkg::ADR_TMR:    rdat_r <= 32'(tmr_r);
				sswe_pkg::ADR_PORT:   rdat_r <= 32'(latch_r) |
				    (32'(pins_s_r) << sswe_pkg::PORT_PIN_LSB);
				sswe_pkg::ADR_PC:     rdat_r <= 32'(pc_r);
				default:              rdat_r <= '0;
			endcase
		end
	end

	// control register: prescaler owner and wake pulse
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			psa_r  <= sswe_pkg::CTRL_PSA_RST;
			wake_r <= 1'b0;
		end else begin
			wake_r <= bus_wr && wb_adr_i == sswe_pkg::ADR_CTRL &&
			          wb_sel_i[0] && wb_dat_i[sswe_pkg::CTRL_WAKE_BIT];
			if (bus_wr && wb_adr_i == sswe_pkg::ADR_CTRL && wb_sel_i[0]) begin
				psa_r <= wb_dat_i[sswe_pkg::CTRL_PSA_BIT];
			end
		end
	end

	// prefetch word; a new write wins over consumption in the same cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			fetch_r     <= sswe_pkg::OP_NOP;
			fetch_vld_r <= 1'b0;
		end else if (bus_wr && wb_adr_i == sswe_pkg::ADR_FETCH) begin
			fetch_r     <= IW_W'(sswe_merge(32'(fetch_r), wb_dat_i, wb_sel_i));
			fetch_vld_r <= 1'b1;
		end else if (at_q4 && !skip_r && !is_goto) begin
			fetch_vld_r <= 1'b0;
		end
	end

	// instruction register and program counter
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ir_r <= sswe_pkg::OP_NOP;
			pc_r <= '0;
		end else if (cif.running) begin
			if (cif.q == sswe_pkg::Q1) begin
				pc_r <= pc_r + 1'b1; // see RULE_13
			end
			if (at_q4) begin
				if (is_goto) begin
					pc_r <= ir_r[sswe_pkg::PC_W-1:0];
					ir_r <= sswe_pkg::OP_NOP; // see RULE_03
				end else if (skip_r) begin
					ir_r <= sswe_pkg::OP_NOP; // see RULE_03
				end else begin
					ir_r <= fetch_vld_r ? fetch_r : sswe_pkg::OP_NOP; // see RULE_13
				end
			end
		end
	end

	// Q2 operand read, Q3 compute
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			opnd_r <= '0;
			alu_r  <= '0;
		end else if (cif.running && cif.q == sswe_pkg::Q2) begin
			if (is_subtract_w_from_literal) begin
				opnd_r <= ir_r[7:0]; // see RULE_09
			end else if (f_adr == sswe_pkg::F_PORT) begin
				opnd_r <= pins_s_r; // see RULE_01
			end else if (f_adr == sswe_pkg::F_TIMER_ZERO_COUNT) begin
				opnd_r <= tmr_r;
			end else begin
				opnd_r <= sswe_pkg::RESET_VAL_8;
			end
		end else if (cif.running && cif.q == sswe_pkg::Q3) begin
			if (is_subtract_w_from_literal) begin
				alu_r <= sswe_sub(opnd_r, w_r); // see RULE_07
			end else begin
				case (bop)
					sswe_pkg::BOP_MOVWF:  alu_r <= {2'b00, w_r};
					sswe_pkg::BOP_COMF:   alu_r <= {2'b00, ~opnd_r};
					sswe_pkg::BOP_INCF:   alu_r <= {2'b00, opnd_r + 8'h01};
					sswe_pkg::BOP_DECFSZ: alu_r <= {2'b00, opnd_r - 8'h01};
					default:              alu_r <= {2'b00, opnd_r};
				endcase
			end
		end
	end

	// skip decision for decrement-and-skip, held through Q4
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			skip_r <= 1'b0;
		end else if (cif.running && cif.q == sswe_pkg::Q3) begin
			skip_r <= is_byte && bop == sswe_pkg::BOP_DECFSZ &&
			          opnd_r == 8'h01;
		end else if (at_q4) begin
			skip_r <= 1'b0;
		end
	end

	// working register and arithmetic flags, Q4 write
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			w_r  <= sswe_pkg::RESET_VAL_8;
			c_r  <= 1'b0;
			dc_r <= 1'b0;
			z_r  <= 1'b0;
		end else if (at_q4 && is_subtract_w_from_literal) begin
			w_r  <= alu_r[7:0]; // see RULE_09
			c_r  <= alu_r[8]; // see RULE_08
			dc_r <= alu_r[9]; // see RULE_08
			z_r  <= alu_r[7:0] == 8'h00; // see RULE_08
		end else if (at_q4 && is_byte) begin
			if (!d_file) begin
				w_r <= alu_r[7:0];
			end
			if (bop == sswe_pkg::BOP_MOVF || bop == sswe_pkg::BOP_COMF ||
			    bop == sswe_pkg::BOP_INCF) begin
				z_r <= alu_r[7:0] == 8'h00;
			end
		end else if (bus_wr && wb_adr_i == sswe_pkg::ADR_W && wb_sel_i[0]) begin
			w_r <= wb_dat_i[7:0];
		end
	end

	// powerdown and timeout flags
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pd_r <= 1'b1;
			to_r <= 1'b1;
		end else if (at_q4 && is_sleep) begin
			pd_r <= 1'b0; // see RULE_05
			to_r <= 1'b1; // see RULE_05
		end else if (at_q4 && is_watchdog_clear_instr) begin
			pd_r <= 1'b1; // see RULE_12
			to_r <= 1'b1; // see RULE_12
		end else if (cif.running && wdt_r == sswe_pkg::CNT_MAX &&
		             (psa_r ? presc_r == sswe_pkg::CNT_MAX : at_q4)) begin
			to_r <= 1'b0;
		end
	end

	// shared prescaler, watchdog and timer zero
	logic wdt_clr;
	logic tmr_wr_i;
	logic tmr_wr_b;
	logic tick;
	logic wrap;
	assign wdt_clr  = at_q4 && (is_sleep || is_watchdog_clear_instr);
	assign tmr_wr_i = at_q4 && is_wrf && f_adr == sswe_pkg::F_TIMER_ZERO_COUNT;
	assign tmr_wr_b = bus_wr && wb_adr_i == sswe_pkg::ADR_TMR && wb_sel_i[0];
	assign tick     = at_q4;
	assign wrap     = presc_r == sswe_pkg::CNT_MAX;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			presc_r <= sswe_pkg::RESET_VAL_8;
			wdt_r   <= sswe_pkg::RESET_VAL_8;
			tmr_r   <= sswe_pkg::RESET_VAL_8;
		end else begin
			if (wdt_clr) begin
				wdt_r <= sswe_pkg::RESET_VAL_8; // see RULE_04
			end else if (tick && (!psa_r || wrap)) begin
				wdt_r <= wdt_r + 8'h01;
			end
			if (wdt_clr && psa_r) begin
				presc_r <= sswe_pkg::RESET_VAL_8; // see RULE_04
			end else if ((tmr_wr_i || tmr_wr_b) && !psa_r) begin
				presc_r <= sswe_pkg::RESET_VAL_8; // see RULE_02
			end else if (tick) begin
				presc_r <= presc_r + 8'h01;
			end
			if (tmr_wr_i) begin
				tmr_r <= alu_r[7:0];
			end else if (tmr_wr_b) begin
				tmr_r <= wb_dat_i[7:0];
			end else if (tick && (psa_r || wrap)) begin
				tmr_r <= tmr_r + 8'h01;
			end
		end
	end

	// port output latch
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			latch_r <= sswe_pkg::RESET_VAL_8;
		end else if (at_q4 && is_wrf && f_adr == sswe_pkg::F_PORT) begin
			latch_r <= alu_r[7:0]; // see RULE_01
		end else if (bus_wr && wb_adr_i == sswe_pkg::ADR_PORT && wb_sel_i[0]) begin
			latch_r <= wb_dat_i[7:0];
		end
	end

	AST_SUB_W: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cif.running && cif.q == sswe_pkg::Q1 && is_subtract_w_from_literal) ##3 at_q4
		|=> w_r == $past(ir_r[7:0], 4) - $past(w_r, 4)) // see RULE_07
		else $error("subtract result wrong");

	AST_SUB_C: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(at_q4 && is_subtract_w_from_literal) |=> c_r == ($past(ir_r[7:0]) >= $past(w_r))
		&& z_r == ($past(ir_r[7:0]) == $past(w_r))) // see RULE_08
		else $error("subtract flags wrong");

	AST_SLEEP_FLAGS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(at_q4 && is_sleep) |=> !pd_r && to_r && wdt_r == 8'h00
		&& $stable(c_r) && $stable(z_r)) // see RULE_05
		else $error("standby flags wrong");

	AST_SLEEP_HALT: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_06
		(at_q4 && is_sleep) |=> cif.standby ##1 (cif.standby || $past(wake_r)))
		else $error("standby not entered");

	AST_SLEEP_PRESC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(at_q4 && is_sleep && psa_r) |=> presc_r == 8'h00) // see RULE_04
		else $error("prescaler not cleared");

	AST_TMR_PRESC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(tmr_wr_i && !psa_r && !wdt_clr) |=> presc_r == 8'h00) // see RULE_02
		else $error("prescaler kept after timer write");

	AST_RMW_PIN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cif.running && cif.q == sswe_pkg::Q2 && is_wrf &&
		 bop == sswe_pkg::BOP_MOVF && f_adr == sswe_pkg::F_PORT)
		##2 at_q4 |=> latch_r == $past(pins_s_r, 3)) // see RULE_01
		else $error("port written from latch");

	AST_FLUSH: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(at_q4 && (is_goto || skip_r)) |=> ir_r == sswe_pkg::OP_NOP
		##4 !(skip_r || is_goto)) // see RULE_03
		else $error("second cycle not a no-operation");

	AST_WATCHDOG_CLEAR_INSTR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(at_q4 && is_watchdog_clear_instr) |=> pd_r && to_r && wdt_r == 8'h00
		&& $stable(w_r) && $stable(c_r)) // see RULE_12
		else $error("watchdog clear wrong");

	AST_ACK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ack_r |=> !ack_r)
		else $error("ack held too long");
endmodule

// ===== rtl/sswe_qgen.sv
// Purpose: quarter-phase generator with oscillator start-up timer
// Assumes: one clk_i edge per oscillator period
// Notes:   phases stand still in standby, as the oscillator would
`timescale 1ns/1ps
module sswe_qgen (
	input  wire logic   clk_i,
	input  wire logic   sys_rst_i,
	sswe_clk_if.gen     cif
);
	sswe_pkg::sswe_clk_state_t  state_r;
	logic [1:0]                 q_r;
	logic [sswe_pkg::OST_CNT_W-1:0] ost_cnt_r;

	localparam logic [sswe_pkg::OST_CNT_W-1:0] OST_LAST =
		sswe_pkg::OST_CNT_W'(sswe_pkg::OST_CYC - 1);

	assign cif.q        = q_r;
	assign cif.running  = (state_r == sswe_pkg::SSWE_RUN);
	assign cif.standby  = (state_r == sswe_pkg::SSWE_HALT);
	assign cif.ost_busy = (state_r == sswe_pkg::SSWE_OST);

	// start-up count, quarter stepping and standby entry
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_r   <= sswe_pkg::SSWE_OST;
			q_r       <= sswe_pkg::Q1;
			ost_cnt_r <= '0;
		end else begin
			case (state_r)
				sswe_pkg::SSWE_OST: begin
					if (ost_cnt_r == OST_LAST) begin // see RULE_11
						state_r   <= sswe_pkg::SSWE_RUN;
						ost_cnt_r <= '0;
					end else begin
						ost_cnt_r <= ost_cnt_r + 1'b1;
					end
					q_r <= sswe_pkg::Q1;
				end
				sswe_pkg::SSWE_RUN: begin
					q_r <= q_r + 1'b1; // see RULE_10
					if (q_r == sswe_pkg::Q4 && cif.halt_req) begin
						state_r <= sswe_pkg::SSWE_HALT; // see RULE_06
					end
				end
				sswe_pkg::SSWE_HALT: begin
					if (cif.wake_req) begin
						state_r <= sswe_pkg::SSWE_OST;
					end
				end
				default: begin
					state_r <= sswe_pkg::SSWE_OST;
				end
			endcase
		end
	end

	// release to run only after the full start-up count
	AST_OST_FULL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(cif.running) |-> $past(ost_cnt_r) == OST_LAST) // see RULE_11
		else $error("start-up count too short");

	// four clocks make one instruction cycle
	AST_QUAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(cif.running && q_r == sswe_pkg::Q1) ##1 cif.running[*3]
		|-> q_r == sswe_pkg::Q4) // see RULE_10
		else $error("quarter sequence broken");
endmodule

// ===== tb/sswe_core_tb_top.sv
// Purpose: self-checking bench for the standby/subtract execute core
// Assumes: wishbone ack one cycle after a request, fetch word fed by bus
// Notes:   reads leave a note in a queue, a monitor compares at each ack
`timescale 1ns/1ps
module sswe_core_tb_top;
	typedef struct {
		logic [31:0] m;
		logic [31:0] e;
	} sswe_note_t;

	logic        clk_i     = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        wb_cyc    = 1'b0;
	logic        wb_stb    = 1'b0;
	logic        wb_we     = 1'b0;
	logic [7:0]  wb_adr    = 8'h00;
	logic [3:0]  wb_sel    = 4'hf;
	logic [31:0] wb_wdat   = 32'h0;
	logic [7:0]  pins      = 8'h5a;
	logic [31:0] rdat;
	logic        ack;
	logic [7:0]  latch;
	logic        stby;
	logic [1:0]  q;
	sswe_note_t  notes[$];
	sswe_note_t  nt;
	int          errors      = 0;
	int          checks_done = 0;
	int          cnt         = 0;
	logic [31:0] rv;
	logic [7:0]  k;
	logic [7:0]  w;
	logic [7:0]  r;
	logic [2:0]  fl;
	logic [1:0]  qp;

	sswe_core dut (
		.clk_i        (clk_i),
		.sys_rst_i    (sys_rst_i),
		.wb_cyc_i     (wb_cyc),
		.wb_stb_i     (wb_stb),
		.wb_we_i      (wb_we),
		.wb_adr_i     (wb_adr),
		.wb_sel_i     (wb_sel),
		.wb_dat_i     (wb_wdat),
		.wb_dat_o     (rdat),
		.wb_ack_o     (ack),
		.port_pins_i  (pins),
		.port_latch_o (latch),
		.standby_o    (stby),
		.q_phase_o    (q)
	);

	// oscillator clock, 10 ns
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// cycles since reset release
	always @(posedge clk_i) begin
		cnt <= sys_rst_i ? 0 : cnt + 1;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	// monitor: oldest note against each answer
	always @(posedge clk_i) begin
		if (ack === 1'b1 && notes.size() > 0) begin
			nt = notes.pop_front();
			if (nt.m != 32'h0)
				chk(rdat & nt.m, nt.e);
		end
	end

	// one classic cycle, held until ack is sampled high
	task automatic bus(input logic [7:0] a, input logic we,
		input logic [31:0] d, input logic [31:0] m);
		int n;
		n = 0;
		notes.push_back('{m, d});
		@(posedge clk_i);
		wb_cyc  <= 1'b1;
		wb_stb  <= 1'b1;
		wb_we   <= we;
		wb_adr  <= a;
		wb_wdat <= we ? d : $urandom();
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rv = rdat;
		if (n >= 50)
			errors++;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d, 32'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(a, 1'b0, e, m);
	endtask

	// feed one word, wait for its consumption, then a fixed delay
	task automatic ex(input logic [13:0] op, input int post);
		int n;
		n = 0;
		wr(sswe_pkg::ADR_FETCH, {18'h0, op});
		do begin
			rd(sswe_pkg::ADR_FETCH, 32'h0, 32'h0);
			n++;
		end while (rv[sswe_pkg::FETCH_VALID_BIT] !== 1'b0 && n < 20);
		if (n >= 20)
			errors++;
		repeat (post) @(posedge clk_i);
	endtask

	// hang guard
	initial begin
		#100000;
		errors++;
		wrap_up();
	end

	// main sequence
	initial begin
		void'($urandom(82));
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(sswe_pkg::ADR_STATUS, 32'h7f, 32'h58);
		rd(sswe_pkg::ADR_W, 32'hff, 32'h0);
		rd(sswe_pkg::ADR_CTRL, 32'h3, 32'h2);
		wr(sswe_pkg::ADR_STATUS, 32'h0);
		wr(8'h24, 32'hffffffff);
		rd(8'h24, 32'hffffffff, 32'h0);
		rd(sswe_pkg::ADR_STATUS, 32'h7f, 32'h58);
		while (cnt < 1010) @(posedge clk_i);
		rd(sswe_pkg::ADR_STATUS, 32'h40, 32'h40);
		while (cnt < 1040) @(posedge clk_i);
		rd(sswe_pkg::ADR_STATUS, 32'h40, 32'h0);
		$display("test start-up done");
		// quarters advance once per clock while running
		@(posedge clk_i);
		#1 qp = q;
		repeat (8) begin
			@(posedge clk_i);
			#1 chk({30'h0, q}, {30'h0, qp + 2'h1});
			qp = q;
		end
		$display("test quarters done");
		// subtract: three fixed cases, then random operands
		for (int i = 0; i < 8; i++) begin
			k = (i < 3) ? 8'h02 : 8'($urandom());
			w = (i < 3) ? 8'(i + 1) : 8'($urandom());
			r = k - w;
			fl = {r == 8'h00, k[3:0] >= w[3:0], k >= w};
			wr(sswe_pkg::ADR_W, {24'h0, w});
			ex({sswe_pkg::SUBTRACT_W_FROM_LITERAL_HI, i[0], k}, 8);
			rd(sswe_pkg::ADR_W, 32'hff, {24'h0, r});
			rd(sswe_pkg::ADR_STATUS, 32'h1f, {27'h3, fl});
		end
		$display("test subtract done");
		// port read-modify-write takes pin levels
		pins <= 8'h0f;
		wr(sswe_pkg::ADR_PORT, 32'hff);
		ex({sswe_pkg::BYTE_HI, sswe_pkg::BOP_MOVF, 1'b1,
			sswe_pkg::F_PORT}, 8);
		chk({24'h0, latch}, 32'h0f);
		fl[2] = 1'b0;
		// decrement of pin value 1 gives zero into w and a taken skip
		pins <= 8'h01;
		ex({sswe_pkg::BYTE_HI, sswe_pkg::BOP_DECFSZ, 1'b0,
			sswe_pkg::F_PORT}, 8);
		rd(sswe_pkg::ADR_W, 32'hff, 32'h0);
		$display("test port done");
		// jump, then standby
		ex({sswe_pkg::GOTO_HI, 11'h123}, 0);
		ex(sswe_pkg::OP_SLEEP, 12);
		chk({31'h0, stby}, 32'h1);
		rd(sswe_pkg::ADR_PC, 32'h7ff, 32'h125);
		rd(sswe_pkg::ADR_STATUS, 32'h3f, {26'h0, 3'b110, fl});
		rd(sswe_pkg::ADR_WDT, 32'hff, 32'h0);
		qp = q;
		repeat (8) @(posedge clk_i);
		chk({30'h0, q}, {30'h0, qp});
		$display("test standby done");
		// wake, start-up again, then watchdog clear
		wr(sswe_pkg::ADR_CTRL, 32'h3);
		repeat (1040) @(posedge clk_i);
		rd(sswe_pkg::ADR_STATUS, 32'h7f, {25'h0, 4'b0010, fl});
		ex(sswe_pkg::OP_WATCHDOG_CLEAR_INSTR, 8);
		rd(sswe_pkg::ADR_STATUS, 32'h3f, {26'h0, 3'b011, fl});
		$display("test wake done");
		wrap_up();
	end
endmodule
